// ---- hdl/tio_params.svh ----
/*
 constants of the terminal I/O mapping block: addresses, limits, resets,
 scaling and timing. assumes byte addresses on a 7-bit AXI4-Lite bus.
*/
`ifndef TIO_PARAMS_SVH
`define TIO_PARAMS_SVH
`define CLK_PERIOD_NS 4
`define NS_PER_MS 1000000
`define FILT_STEP_MS 1
`define A_AO3 7'h00
`define A_AO4 7'h20
`define F_SRC 3'd0
`define F_MODE 3'd1
`define F_FTIME 3'd2
`define F_OFFS 3'd3
`define F_NORM 3'd4
`define A_BIN1 7'h40
`define A_BIN4_2 7'h54
`define A_POSCFG 7'h58
`define A_STATUS 7'h5c
`define A_VOLT3 7'h60
`define A_VOLT4 7'h64
`define ST_INHIBIT 0
`define ST_OPER 1
`define SRC_MAX 32'sd399
`define MODE_MAX 32'sd3
`define FTIME_MAX 32'sd10000
`define OFFS_LIM 32'sd2000
`define NORM_LIM 32'sd20000
`define FUNC_MAX 32'sd68
`define FUNC_RSVD 32'sd1
`define POSCFG_MAX 32'sd999
`define NORM_RST 16'sd1000
`define SRC_ZERO_A 9'd0
`define SRC_ZERO_B 9'd2
`define MODE_ABS 0
`define MODE_INV 1
`define PCT_SHIFT 14
`define NORM_UNIT 48'sd1000
`define OFFS_UNIT 48'sd533
`define FRAC_ZERO 16'h0000
`define DIV_STEPS 6'd34
`define FUNC_FIRST 7'd2
`define FUNC_LAST 7'd68
`define FUNC_CNT 69
`define PC_DIGIT_A 10'd2
`define PC_DIGIT_B 10'd3
`define DEC_BASE 10'd10
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RESP_DECERR 2'b11
`endif

// ---- hdl/tio_pkg.sv ----
/*
 types of the terminal I/O mapping block.
 assumes nothing of its surroundings.
*/
package tio_pkg;
  typedef enum logic [0:0] {
    F_IDLE = 1'b0,
    F_DIV = 1'b1
  } filt_state_e;
endpackage

// ---- hdl/bin_func_decode.sv ----
/*
 one function slot of a binary input: code and level to a one-hot vector.
 assumes the code was range-checked when written.
*/
`timescale 1ns/10ps
`include "tio_params.svh"
module bin_func_decode (
  input wire logic [6:0] code,
  input wire logic level,
  output logic [`FUNC_CNT-1:0] func_vec
);
  wire real_fn;
  assign real_fn = code >= `FUNC_FIRST && code <= `FUNC_LAST; // RQ9
  assign func_vec = (level && real_fn) ? (`FUNC_CNT'(1) << code) : '0;
endmodule

// ---- hdl/aout_channel.sv ----
/*
 one analog output channel: source pick, sign conditioning, low-pass,
 scaling and offset. assumes conn_value belongs to the number on src_sel
 in the same cycle and tick is a one-cycle pulse per filter step.
*/
`timescale 1ns/10ps
`include "tio_params.svh"
module aout_channel
  import tio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic [8:0] src_sel,
  input wire logic [1:0] sign_mode,
  input wire logic [13:0] filter_time,
  input wire logic signed [11:0] offset,
  input wire logic signed [15:0] norm,
  input wire logic signed [15:0] conn_value,
  output logic signed [31:0] voltage
);
  wire is_zero;
  wire signed [16:0] sel_val;
  wire signed [16:0] mag;
  wire signed [16:0] cond;
  wire signed [32:0] x_q;
  wire signed [33:0] diff;
  wire [33:0] dvd_mag;
  wire [14:0] rem_sh;
  wire ge;
  wire [14:0] rem_nx;
  wire [33:0] quo_nx;
  wire signed [32:0] y_upd;
  wire signed [16:0] y_out;
  wire signed [47:0] scaled;
  wire signed [47:0] offs_term;
  filt_state_e st_reg;
  logic signed [32:0] y_q_reg;
  logic [5:0] cnt_reg;
  logic [14:0] rem_reg;
  logic [33:0] quo_reg;
  logic neg_reg;
  logic [14:0] div_reg;
  logic signed [31:0] volt_reg;

  assign is_zero = src_sel == `SRC_ZERO_A || src_sel == `SRC_ZERO_B; // RQ1
  assign sel_val = is_zero ? 17'sd0 : 17'(conn_value); // RQ1
  assign mag = (sign_mode[`MODE_ABS] && sel_val[16]) ? -sel_val : sel_val; // RQ2
  assign cond = sign_mode[`MODE_INV] ? -mag : mag; // RQ2
  assign x_q = {cond, `FRAC_ZERO};
  assign diff = 34'(x_q) - 34'(y_q_reg);
  assign dvd_mag = diff[33] ? 34'(-diff) : 34'(diff);
  assign rem_sh = {rem_reg[13:0], quo_reg[33]};
  assign ge = rem_sh >= div_reg;
  assign rem_nx = ge ? 15'(rem_sh - div_reg) : rem_sh;
  assign quo_nx = {quo_reg[32:0], ge};
  assign y_upd = neg_reg ? 33'(y_q_reg - $signed({1'b0, quo_nx}))
                         : 33'(y_q_reg + $signed({1'b0, quo_nx}));
  assign y_out = y_q_reg[32:16];
  assign scaled = (48'(y_out) * 48'(norm) * `NORM_UNIT) >>> `PCT_SHIFT; // RQ5
  assign offs_term = 48'(offset) * `OFFS_UNIT; // RQ4
  assign voltage = volt_reg;

  // first-order step: y += (x - y) / (T + 1), by serial division
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= F_IDLE;
      y_q_reg <= '0;
      cnt_reg <= '0;
      rem_reg <= '0;
      quo_reg <= '0;
      neg_reg <= 1'b0;
      div_reg <= '0;
    end else if (filter_time == '0) begin
      st_reg <= F_IDLE; // RQ3
      y_q_reg <= x_q; // RQ3
    end else begin
      unique case (st_reg)
        F_IDLE: begin
          if (tick) begin
            st_reg <= F_DIV; // RQ14
            quo_reg <= dvd_mag;
            neg_reg <= diff[33];
            rem_reg <= '0;
            cnt_reg <= `DIV_STEPS;
            div_reg <= 15'(filter_time) + 15'd1; // RQ14
          end
        end
        F_DIV: begin
          rem_reg <= rem_nx;
          quo_reg <= quo_nx;
          cnt_reg <= cnt_reg - 6'd1;
          if (cnt_reg == 6'd1) begin
            y_q_reg <= y_upd; // RQ14
            st_reg <= F_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      volt_reg <= '0;
    end else begin
      volt_reg <= 32'(scaled + offs_term); // RQ4 RQ5
    end
  end
endmodule

// ---- hdl/tio_map.sv ----
/*
 terminal I/O mapping: two analog output channels and four binary input
 terminals configured over AXI4-Lite. assumes one clock aclk, inputs
 synchronous to it, and connector values supplied per selected number.
*/
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
// Operation
// RQ1 - source select routes signal; 0 and 2 zero
// RQ2 - sign mode: signed, absolute, inverted, both
// RQ3 - filter time 0..10000 ms, zero bypasses
// RQ4 - signed offset in 5.33 mV steps, +-2000
// RQ5 - output is percent over 100% times normalization
// RQ6 - normalization default 10.00 V, 0.01 V steps
// RQ7 - analog settings other than normalization reset to zero
// RQ8 - analog settings change while running
// RQ9 - binary function codes 0..68, 1 reserved
// RQ10 - binary functions writable only when off-line
// RQ11 - config digit 2/3: input 1 resets counter
// RQ12 - input four carries three functions together
// RQ13 - off-line change raises switch-on inhibit
// RQ14 - filter is first-order, fixed sample rate
`timescale 1ns/10ps
`include "tio_params.svh"
module tio_map
  import tio_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `FILT_STEP_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [6:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [6:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic signed [15:0] aout3_conn_value,
  input wire logic signed [15:0] aout4_conn_value,
  output logic [8:0] aout3_conn_num,
  output logic [8:0] aout4_conn_num,
  output logic signed [31:0] aout3_voltage,
  output logic signed [31:0] aout4_voltage,
  input wire logic [3:0] bin_in,
  input wire logic drive_operating,
  input wire logic inhibit_ack,
  output logic [`FUNC_CNT-1:0] func_active,
  output logic pos_counter_reset,
  output logic switch_on_inhibit
);
  // analog output settings, index 0 is channel 3
  logic [8:0] src_reg [2];
  logic [1:0] mode_reg [2];
  logic [13:0] ftime_reg [2];
  logic signed [11:0] offs_reg [2];
  logic signed [15:0] norm_reg [2];
  // function slots: in1, in2, in3, in4 list 0..2
  logic [6:0] code_reg [6];
  logic [9:0] poscfg_reg;
  logic inhibit_reg;
  logic [`FUNC_CNT-1:0] func_reg;
  logic pos_rst_reg;
  logic [31:0] tick_cnt_reg;
  logic aw_held_reg;
  logic [6:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [`FUNC_CNT-1:0] slot_vec [6];
  logic [`FUNC_CNT-1:0] func_next;
  wire signed [31:0] volt [2];

  // register read view
  function automatic logic [31:0] read_word(input logic [6:0] a);
    logic [31:0] r;
    logic c;
    logic [2:0] slot;
    r = 32'h0000_0000;
    c = a[5];
    slot = 3'((a - `A_BIN1) >> 2);
    if (!a[6] && a[4:2] <= `F_NORM) begin
      case (a[4:2])
        `F_SRC: r = 32'(src_reg[c]);
        `F_MODE: r = 32'(mode_reg[c]);
        `F_FTIME: r = 32'(ftime_reg[c]);
        `F_OFFS: r = 32'(offs_reg[c]);
        default: r = 32'(norm_reg[c]);
      endcase
    end else if (a >= `A_BIN1 && a <= `A_BIN4_2) begin
      r = 32'(code_reg[slot]);
    end else begin
      case (a)
        `A_POSCFG: r = 32'(poscfg_reg);
        `A_STATUS: begin
          r[`ST_INHIBIT] = inhibit_reg;
          r[`ST_OPER] = drive_operating;
        end
        `A_VOLT3: r = volt[0];
        `A_VOLT4: r = volt[1];
        default: r = 32'h0000_0000;
      endcase
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [6:0] a);
    return (!a[6] && a[4:2] <= `F_NORM) || (a >= `A_BIN1 && a <= `A_VOLT4);
  endfunction

  // write path decode
  wire do_wr;
  wire [6:0] wa;
  wire wr_ch;
  wire [2:0] wr_field;
  wire [2:0] wr_slot;
  wire wr_ao;
  wire wr_bin;
  wire wr_pc;
  wire wr_offline;
  wire [31:0] wmask;
  wire [31:0] merged;
  logic [31:0] cur_word;
  wire signed [31:0] ms;
  wire ao_rng;
  wire fn_rng;
  wire pc_rng;
  wire wr_ok;
  wire [1:0] wr_resp;
  wire [6:0] ra;
  wire ar_take;
  wire inhibit_set;
  wire [9:0] pc_digit;
  wire pc_reset_mode;
  wire tick;

  assign do_wr = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wa = aw_addr_reg;
  assign wr_ch = wa[5];
  assign wr_field = wa[4:2];
  assign wr_slot = 3'((wa - `A_BIN1) >> 2);
  assign wr_ao = !wa[6] && wr_field <= `F_NORM;
  assign wr_bin = wa >= `A_BIN1 && wa <= `A_BIN4_2;
  assign wr_pc = wa == `A_POSCFG;
  assign wr_offline = wr_bin || wr_pc;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                  {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  // process, so the merge also follows changes of the settings read
  always_comb begin
    cur_word = read_word(wa);
  end
  assign merged = (cur_word & ~wmask) | (w_data_reg & wmask);
  assign ms = merged;
  assign ao_rng = (wr_field == `F_SRC && ms >= 0 && ms <= `SRC_MAX) // RQ1
               || (wr_field == `F_MODE && ms >= 0 && ms <= `MODE_MAX) // RQ2
               || (wr_field == `F_FTIME && ms >= 0 && ms <= `FTIME_MAX) // RQ3
               || (wr_field == `F_OFFS && ms >= -`OFFS_LIM && ms <= `OFFS_LIM) // RQ4
               || (wr_field == `F_NORM && ms >= -`NORM_LIM && ms <= `NORM_LIM); // RQ6
  assign fn_rng = ms >= 0 && ms <= `FUNC_MAX && ms != `FUNC_RSVD; // RQ9
  assign pc_rng = ms >= 0 && ms <= `POSCFG_MAX;
  // analog writes are accepted at any time, off-line ones only when stopped
  assign wr_ok = (wr_ao && ao_rng) // RQ8
              || (wr_bin && fn_rng && !drive_operating) // RQ10
              || (wr_pc && pc_rng && !drive_operating); // RQ10
  assign wr_resp = wr_ok ? `RESP_OKAY
                 : (mapped(wa) ? `RESP_SLVERR : `RESP_DECERR);
  assign inhibit_set = do_wr && wr_ok && wr_offline; // RQ13

  assign ra = {araddr[6:2], 2'b00};
  assign ar_take = arvalid && arready;

  assign awready = !aw_held_reg;
  assign wready = !w_held_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // bus handshakes, one write and one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {awaddr[6:2], 2'b00};
      end else if (do_wr) begin
        aw_held_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end else if (do_wr) begin
        w_held_reg <= 1'b0;
      end
      if (do_wr) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_resp;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= mapped(ra) ? read_word(ra) : 32'h0000_0000;
      rresp_reg <= mapped(ra) ? `RESP_OKAY : `RESP_DECERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // analog output settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2; i++) begin
        src_reg[i] <= '0; // RQ7
        mode_reg[i] <= '0; // RQ7
        ftime_reg[i] <= '0; // RQ7
        offs_reg[i] <= '0; // RQ7
        norm_reg[i] <= `NORM_RST; // RQ6
      end
    end else if (do_wr && wr_ok && wr_ao) begin
      case (wr_field)
        `F_SRC: src_reg[wr_ch] <= merged[8:0]; // RQ1
        `F_MODE: mode_reg[wr_ch] <= merged[1:0]; // RQ2
        `F_FTIME: ftime_reg[wr_ch] <= merged[13:0]; // RQ3
        `F_OFFS: offs_reg[wr_ch] <= merged[11:0]; // RQ4
        default: norm_reg[wr_ch] <= merged[15:0]; // RQ6
      endcase
    end
  end

  // binary input settings and switch-on inhibit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 6; i++) begin
        code_reg[i] <= '0; // RQ9
      end
      poscfg_reg <= '0;
      inhibit_reg <= 1'b0;
    end else begin
      if (do_wr && wr_ok && wr_bin) begin
        code_reg[wr_slot] <= merged[6:0]; // RQ9
      end
      if (do_wr && wr_ok && wr_pc) begin
        poscfg_reg <= merged[9:0]; // RQ11
      end
      // a new set wins over a same-cycle acknowledge
      if (inhibit_set) begin
        inhibit_reg <= 1'b1; // RQ13
      end else if (inhibit_ack) begin
        inhibit_reg <= 1'b0;
      end
    end
  end

  // filter step timebase
  assign tick = tick_cnt_reg == 32'(MS_CYCLES - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt_reg <= '0; // RQ14
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'd1;
    end
  end

  // function slots; the three slots of input four share its level
  for (genvar g = 0; g < 6; g++) begin : g_slot
    bin_func_decode u_dec (
      .code(code_reg[g]),
      .level(bin_in[(g < 3) ? g : 3]), // RQ12
      .func_vec(slot_vec[g])
    );
  end

  always_comb begin
    func_next = '0;
    for (int i = 0; i < 6; i++) begin
      func_next = func_next | slot_vec[i]; // RQ12
    end
  end

  assign pc_digit = poscfg_reg % `DEC_BASE;
  assign pc_reset_mode = pc_digit == `PC_DIGIT_A || pc_digit == `PC_DIGIT_B;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_reg <= '0;
      pos_rst_reg <= 1'b0;
    end else begin
      func_reg <= func_next; // RQ9
      pos_rst_reg <= bin_in[0] && pc_reset_mode; // RQ11
    end
  end

  assign func_active = func_reg;
  assign pos_counter_reset = pos_rst_reg;
  assign switch_on_inhibit = inhibit_reg;
  assign aout3_conn_num = src_reg[0];
  assign aout4_conn_num = src_reg[1];
  assign aout3_voltage = volt[0];
  assign aout4_voltage = volt[1];

  aout_channel u_aout3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .src_sel(src_reg[0]),
    .sign_mode(mode_reg[0]),
    .filter_time(ftime_reg[0]),
    .offset(offs_reg[0]),
    .norm(norm_reg[0]),
    .conn_value(aout3_conn_value),
    .voltage(volt[0])
  );

  aout_channel u_aout4 (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .src_sel(src_reg[1]),
    .sign_mode(mode_reg[1]),
    .filter_time(ftime_reg[1]),
    .offset(offs_reg[1]),
    .norm(norm_reg[1]),
    .conn_value(aout4_conn_value),
    .voltage(volt[1])
  );
endmodule

// ---- dv/tio_map_sva.sv ----
/*
 checker of the terminal I/O mapping block's ports.
 assumes one clock aclk and the synchronous active-low reset aresetn.
*/
`timescale 1ns/10ps
module tio_map_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [8:0] aout3_conn_num,
  input wire logic [3:0] bin_in,
  input wire logic [68:0] func_active,
  input wire logic pos_counter_reset,
  input wire logic switch_on_inhibit,
  input wire logic inhibit_ack
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer missing");
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("write answer missing");
  src_range_a: assert property (aout3_conn_num <= 9'h18f)
    else $error("source number above limit");
  src_change_a: assert property ($changed(aout3_conn_num) |-> bvalid || $past(bvalid))
    else $error("source changed without write");
  func_low_a: assert property (func_active[1:0] == 2'h0)
    else $error("reserved function active");
  pos_reset_a: assert property (pos_counter_reset |-> $past(bin_in[0]))
    else $error("counter reset without input");
  inh_set_a: assert property ($rose(switch_on_inhibit) |-> $rose(bvalid))
    else $error("inhibit set without write");
  inh_clear_a: assert property ($fell(switch_on_inhibit) |-> $past(inhibit_ack))
    else $error("inhibit cleared without ack");
  reset_val_a: assert property ($rose(aresetn) |-> aout3_conn_num == 9'h0 && !switch_on_inhibit)
    else $error("reset value wrong");
endmodule
bind tio_map tio_map_sva chk_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .aout3_conn_num(aout3_conn_num), .bin_in(bin_in),
  .func_active(func_active), .pos_counter_reset(pos_counter_reset),
  .switch_on_inhibit(switch_on_inhibit), .inhibit_ack(inhibit_ack));

// ---- dv/tio_map_tb.sv ----
/*
 self-checking bench of the terminal I/O mapping block: AXI4-Lite tasks.
 assumes the block's conn numbers need no model: one value feeds both.
*/
`timescale 1ns/10ps
`include "tio_params.svh"
module tio_map_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic drive_operating, inhibit_ack, pos_counter_reset, switch_on_inhibit;
  logic [6:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, bin_in;
  logic [1:0] bresp, rresp;
  logic signed [15:0] cv;
  logic signed [31:0] v3, v4;
  logic [8:0] n3, n4;
  logic [68:0] func_active;
  int num_errors, num_checks;

  tio_map #(.MS_CYCLES(20)) dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .aout3_conn_value(cv), .aout4_conn_value(cv), .aout3_conn_num(n3),
    .aout4_conn_num(n4), .aout3_voltage(v3), .aout4_voltage(v4), .bin_in(bin_in),
    .drive_operating(drive_operating), .inhibit_ack(inhibit_ack),
    .func_active(func_active), .pos_counter_reset(pos_counter_reset),
    .switch_on_inhibit(switch_on_inhibit));

  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    chk("rdata", rdata, ed);
    chk("rresp", 32'(rresp), 32'(er));
  endtask

  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, drive_operating, inhibit_ack} = '0;
    awaddr = 0;
    araddr = 0;
    wdata = 0;
    wstrb = 0;
    bin_in = 0;
    cv = 0;
    aresetn = 0;
    num_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 10; i++) rd(7'(i * 4 + (i / 5) * 12), (i % 5 == 4) ? 1000 : 0, `RESP_OKAY);
    $display("reset test done");
    wr(`A_AO3, 400, `RESP_SLVERR);
    wr(`A_AO3, 399, `RESP_OKAY);
    settle();
    chk("conn num", 32'(n3), 399);
    cv <= -16'sd8192;
    drive_operating <= 1;
    for (int c = 0; c < 2; c++) begin
      wr(7'(c * 32), 7, `RESP_OKAY);
      for (int m = 0; m < 4; m++) begin
        wr(7'(c * 32 + 4), m, `RESP_OKAY);
        settle();
        chk("mode volt", c ? v4 : v3, (m == 1 || m == 2) ? 500000 : -500000);
      end
    end
    chk("conn num4", 32'(n4), 7);
    wr(`A_AO3 + 7'h10, -500, `RESP_OKAY);
    wr(`A_AO3 + 7'h10, 20001, `RESP_SLVERR);
    settle();
    chk("norm volt", v3, 250000);
    wr(`A_AO3 + 7'h10, 1000, `RESP_OKAY);
    for (int s = 0; s < 3; s += 2) begin
      wr(`A_AO3, s, `RESP_OKAY);
      settle();
      chk("zero src", v3, 0);
    end
    wr(`A_AO3 + 7'h0c, 2001, `RESP_SLVERR);
    wr(`A_AO3 + 7'h0c, -2000, `RESP_OKAY);
    rd(`A_AO3 + 7'h0c, 32'hfffff830, `RESP_OKAY);
    settle();
    chk("offset volt", v3, -1066000);
    wr(`A_AO3 + 7'h04, 4, `RESP_SLVERR);
    wr(`A_AO3 + 7'h08, 10001, `RESP_SLVERR);
    $display("analog test done");
    cv <= 0;
    wr(`A_AO3 + 7'h0c, 0, `RESP_OKAY);
    wr(`A_AO3, 7, `RESP_OKAY);
    wr(`A_AO3 + 7'h04, 0, `RESP_OKAY);
    wr(`A_AO3 + 7'h08, 3, `RESP_OKAY);
    cv <= 16'sd16384;
    repeat (5) @(posedge aclk);
    chk("filter lag", 32'(v3 < 32'sd500000), 1);
    repeat (3000) @(posedge aclk);
    chk("filter end", 32'(v3 > 32'sd990000 && v3 <= 32'sd1000000), 1);
    $display("filter test done");
    wr(`A_BIN1, 1, `RESP_SLVERR);
    wr(`A_BIN1, 69, `RESP_SLVERR);
    wr(`A_BIN1, 5, `RESP_SLVERR);
    chk("no inhibit", 32'(switch_on_inhibit), 0);
    rd(`A_STATUS, 2, `RESP_OKAY);
    drive_operating <= 0;
    wr(`A_BIN1, 5, `RESP_OKAY);
    chk("inhibit", 32'(switch_on_inhibit), 1);
    bin_in <= 4'h1;
    inhibit_ack <= 1;
    @(posedge aclk);
    inhibit_ack <= 0;
    settle();
    chk("ack", 32'(switch_on_inhibit), 0);
    chk("func in1", 32'(func_active === (69'h1 << 5)), 1);
    wr(`A_BIN1 + 7'h0c, 10, `RESP_OKAY);
    wr(`A_BIN1 + 7'h10, 20, `RESP_OKAY);
    wr(`A_BIN4_2, 68, `RESP_OKAY);
    bin_in <= 4'h8;
    settle();
    chk("func in4", 32'(func_active === ((69'h1 << 10) | (69'h1 << 20) | (69'h1 << 68))), 1);
    wr(`A_POSCFG, 1000, `RESP_SLVERR);
    bin_in <= 4'h1;
    for (int p = 12; p < 15; p++) begin
      wr(`A_POSCFG, p, `RESP_OKAY);
      settle();
      chk("pos reset", 32'(pos_counter_reset), 32'(p != 14));
    end
    rd(`A_STATUS, 1, `RESP_OKAY);
    $display("binary test done");
    rd(7'h7c, 0, `RESP_DECERR);
    wr(7'h7c, 0, `RESP_DECERR);
    wr(`A_VOLT3, 0, `RESP_SLVERR);
    $display("map test done");
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    $display("watchdog expired");
    finish_test();
  end
endmodule
